// ---- src/fcb_flash_host.sv ----
// flash command host: register slave, command sequencer, pin driver
// How it works
// - status latched per read; strobe returns high
// - clear status is one 50H write
// - erase is setup then confirm in block
// - completion by ready pin, then ready bit
// - status mode entered by 70H write
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module fcb_flash_host
   import fcb_pkg::*;
#(
   parameter int AW = 21,
   parameter int DW = 16
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output fcb_strobe_s flash_strobe,
   output logic [AW-1:0] flash_addr,
   output logic [DW-1:0] flash_dq_out,
   input wire logic [DW-1:0] flash_dq_in,
   output logic reset_powerdown_n,
   output logic write_protect,
   input wire logic ready_busy_n
);
   if (AW < 2 || AW > 32 || (DW != 8 && DW != 16)) begin : g_bad
      $error("fcb_flash_host: unsupported width");
   end

   typedef enum logic [2:0] {SQ_IDLE, SQ_CMD, SQ_SECOND, SQ_READ, SQ_WAIT_RB, SQ_POLL} fcb_seq_e;
   fcb_seq_e state, next_state;
   logic [2:0] op;
   logic [AW-1:0] addr_reg;
   logic [DW-1:0] wdata_reg;
   logic [DW-1:0] read_value;
   logic [7:0] last_sr;
   logic [7:0] cmd_code;
   logic done_flag;
   logic cyc_pend;
   logic rb_s1;
   logic rb_s2;
   logic [31:0] stat_word;
   logic [31:0] ctrl_word;
   logic [DW-1:0] cyc_wdata;
   logic cyc_done;
   logic [DW-1:0] cyc_rdata;

   // register write decode
   wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
   wire wr_go = awvalid && wvalid && !awready && !bvalid;
   wire [5:0] wr_word = awaddr[7:2];
   wire wr_ctrl = awready && wr_word == REG_CTRL[7:2];
   wire wr_addr = awready && wr_word == REG_ADDR[7:2];
   wire wr_data = awready && wr_word == REG_WDATA[7:2];
   wire wr_known = wr_word inside {REG_CTRL[7:2], REG_ADDR[7:2], REG_WDATA[7:2],
                                   REG_STAT[7:2], REG_RDATA[7:2]};
   wire idle = (state == SQ_IDLE);
   wire ctrl_lo = wr_ctrl && wstrb[0] && idle;
   wire go = ctrl_lo && wdata[CTRL_GO_BIT];
   wire [2:0] op_in = wdata[CTRL_OP_LSB +: 3];
   wire [31:0] addr_merge = (32'(addr_reg) & ~wmask) | (wdata & wmask);
   wire [31:0] data_merge = (32'(wdata_reg) & ~wmask) | (wdata & wmask);

   // register read decode
   wire [5:0] rd_word = araddr[7:2];
   wire rd_known = rd_word inside {REG_CTRL[7:2], REG_ADDR[7:2], REG_WDATA[7:2],
                                   REG_STAT[7:2], REG_RDATA[7:2]};
   wire [31:0] rd_value = (rd_word == REG_CTRL[7:2]) ? ctrl_word :
                          (rd_word == REG_ADDR[7:2]) ? 32'(addr_reg) :
                          (rd_word == REG_WDATA[7:2]) ? 32'(wdata_reg) :
                          (rd_word == REG_STAT[7:2]) ? stat_word :
                          (rd_word == REG_RDATA[7:2]) ? 32'(read_value) : 32'h0000_0000;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[STAT_BUSY_BIT] = !idle;
      stat_word[STAT_DONE_BIT] = done_flag;
      stat_word[STAT_RB_BIT] = rb_s2;
      stat_word[STAT_SR_LSB +: 8] = last_sr;
   end

   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[CTRL_OP_LSB +: 3] = op;
      ctrl_word[CTRL_RP_BIT] = reset_powerdown_n;
      ctrl_word[CTRL_WP_BIT] = write_protect;
   end

   // sequencer: each op is a short chain of flash bus cycles
   wire cyc_state = state inside {SQ_CMD, SQ_SECOND, SQ_READ, SQ_POLL};
   wire cyc_start = cyc_state && !cyc_pend;
   wire cyc_read = state inside {SQ_READ, SQ_POLL};
   wire sr_read = (state == SQ_POLL) || (state == SQ_READ && op == OP_READ_STATUS);
   wire two_write = op inside {OP_BLOCK_ERASE, OP_WORD_WRITE};

   always_comb begin
      case (op)
         OP_READ_ID: cmd_code = CMD_READ_ID;
         OP_READ_STATUS: cmd_code = CMD_READ_STATUS;
         OP_CLEAR_STATUS: cmd_code = CMD_CLEAR_STATUS;
         OP_BLOCK_ERASE: cmd_code = CMD_ERASE_SETUP;
         OP_WORD_WRITE: cmd_code = CMD_WRITE_SETUP;
         default: cmd_code = CMD_READ_ARRAY;
      endcase
   end

   // confirm goes out at the block address held in the address register
   assign cyc_wdata = (state == SQ_CMD) ? DW'(cmd_code) :
                      (op == OP_BLOCK_ERASE) ? DW'(CMD_CONFIRM) : wdata_reg;

   always_comb begin
      next_state = state;
      case (state)
         SQ_IDLE: if (go) next_state = (op_in == OP_READ) ? SQ_READ : SQ_CMD;
         SQ_CMD: begin
            if (cyc_done && two_write) next_state = SQ_SECOND;
            else if (cyc_done && op inside {OP_READ_ID, OP_READ_STATUS}) next_state = SQ_READ;
            else if (cyc_done) next_state = SQ_IDLE;
         end
         SQ_SECOND: if (cyc_done) next_state = SQ_WAIT_RB;
         SQ_READ: if (cyc_done) next_state = SQ_IDLE;
         // the pin may not have dropped yet; the ready bit poll settles it
         SQ_WAIT_RB: if (rb_s2) next_state = SQ_POLL;
         SQ_POLL: if (cyc_done && cyc_rdata[SR_READY_BIT]) next_state = SQ_IDLE;
         default: next_state = SQ_IDLE;
      endcase
   end

   fcb_bus_cycle #(
      .AW(AW),
      .DW(DW)
   ) u_cycle (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(cyc_start),
      .is_read(cyc_read),
      .addr_in(addr_reg),
      .wdata_in(cyc_wdata),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .strobe(flash_strobe),
      .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out),
      .flash_dq_in(flash_dq_in)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         awready <= wr_go;
         wready <= wr_go;
         if (awready) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (arready) begin
            rvalid <= 1'b1;
            rdata <= rd_value;
            rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op <= OP_READ_ARRAY_MODE;
         addr_reg <= '0;
         wdata_reg <= '0;
         reset_powerdown_n <= CTRL_RP_RESET;
         write_protect <= CTRL_WP_RESET;
      end else begin
         if (ctrl_lo) op <= op_in;
         if (wr_ctrl && wstrb[1]) reset_powerdown_n <= wdata[CTRL_RP_BIT];
         if (wr_ctrl && wstrb[1]) write_protect <= wdata[CTRL_WP_BIT];
         if (wr_addr && idle) addr_reg <= addr_merge[AW-1:0];
         if (wr_data && idle) wdata_reg <= data_merge[DW-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= SQ_IDLE;
         cyc_pend <= 1'b0;
         done_flag <= 1'b0;
         last_sr <= 8'h00;
         read_value <= '0;
         rb_s1 <= 1'b1;
         rb_s2 <= 1'b1;
      end else begin
         state <= next_state;
         rb_s1 <= ready_busy_n;
         rb_s2 <= rb_s1;
         if (cyc_start) cyc_pend <= 1'b1;
         else if (cyc_done) cyc_pend <= 1'b0;
         if (go) done_flag <= 1'b0;
         else if (!idle && next_state == SQ_IDLE) done_flag <= 1'b1;
         if (cyc_done && cyc_read) read_value <= cyc_rdata;
         // each poll is a fresh read, so the snapshot is renewed
         if (cyc_done && sr_read) last_sr <= cyc_rdata[7:0];
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_cmd_write(logic [7:0] code);
      cyc_start && !cyc_read && cyc_wdata[7:0] == code;
   endsequence
   sequence s_confirm;
      cyc_start && !cyc_read && cyc_wdata[7:0] == CMD_CONFIRM && flash_strobe.ce_n;
   endsequence

   clear_code_a: assert property (go && op_in == OP_CLEAR_STATUS |=> s_cmd_write(CMD_CLEAR_STATUS) ##1 !cyc_start [*8])
      else $error("clear status not a single 50H write");
   status_entry_a: assert property (go && op_in == OP_READ_STATUS |=> s_cmd_write(CMD_READ_STATUS) ##[1:40] (cyc_start && cyc_read))
      else $error("status read not preceded by 70H write");
   erase_pair_a: assert property (go && op_in == OP_BLOCK_ERASE |=> s_cmd_write(CMD_ERASE_SETUP) ##[1:40] s_confirm)
      else $error("erase setup and confirm not issued in order");
   confirm_addr_a: assert property (state == SQ_SECOND && cyc_start |=> flash_addr == addr_reg)
      else $error("confirm not at block address");
   rb_wait_a: assert property (!rb_s2 |-> !(cyc_start && !cyc_read))
      else $error("device written while ready pin low");
   poll_end_a: assert property (state == SQ_POLL && next_state == SQ_IDLE |=> done_flag && last_sr[SR_READY_BIT])
      else $error("operation finished without ready bit");
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");
endmodule : fcb_flash_host

// ---- shared/fcb_pkg.sv ----
// constants, codes and pin carrier of the flash command host
package fcb_pkg;
   // flash command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
   // identifier space of the device
   localparam logic [20:0] ID_MAKER_ADDR = 21'h0_0000;
   localparam logic [20:0] ID_PART_ADDR = 21'h0_0001;
   localparam logic [20:0] ID_BLOCK_LOCK_OFS = 21'h0_0002;
   localparam logic [20:0] ID_PERM_LOCK_ADDR = 21'h0_0003;
   // device status byte
   localparam int SR_READY_BIT = 7;
   localparam int SR_ERASE_ERR_BIT = 5;
   localparam int SR_PROG_ERR_BIT = 4;
   localparam int SR_SUPPLY_BIT = 3;
   localparam int SR_LOCKED_BIT = 1;
   // host register map
   localparam int AXI_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_GO_BIT = 3;
   localparam int CTRL_RP_BIT = 8;
   localparam int CTRL_WP_BIT = 9;
   localparam logic CTRL_RP_RESET = 1'b1;
   localparam logic CTRL_WP_RESET = 1'b0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_RB_BIT = 2;
   localparam int STAT_SR_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // host operations
   localparam logic [2:0] OP_READ_ARRAY_MODE = 3'h0;
   localparam logic [2:0] OP_READ_ID = 3'h1;
   localparam logic [2:0] OP_READ_STATUS = 3'h2;
   localparam logic [2:0] OP_CLEAR_STATUS = 3'h3;
   localparam logic [2:0] OP_BLOCK_ERASE = 3'h4;
   localparam logic [2:0] OP_WORD_WRITE = 3'h5;
   localparam logic [2:0] OP_READ = 3'h6;
   // bus cycle timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int PULSE_NS = 70;
   localparam int RECOVER_NS = 30;
   localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe_n;
   } fcb_strobe_s;
   localparam fcb_strobe_s STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};
endpackage : fcb_pkg

// ---- src/fcb_bus_cycle.sv ----
// one asynchronous flash bus cycle, read or write
`timescale 1ns/10ps
module fcb_bus_cycle
   import fcb_pkg::*;
#(
   parameter int AW = 21,
   parameter int DW = 16,
   parameter int ACT_CYC = PULSE_CYC + 2,
   parameter int REC_CYC = RECOVER_CYC
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic is_read,
   input wire logic [AW-1:0] addr_in,
   input wire logic [DW-1:0] wdata_in,
   output logic done,
   output logic [DW-1:0] rdata,
   output fcb_strobe_s strobe,
   output logic [AW-1:0] flash_addr,
   output logic [DW-1:0] flash_dq_out,
   input wire logic [DW-1:0] flash_dq_in
);
   // read data lags two sync stages, so the pulse must outlast them
   if (ACT_CYC < PULSE_CYC + 2 || ACT_CYC > 255 || REC_CYC < 1 || REC_CYC > 255) begin : g_bad
      $error("fcb_bus_cycle: unsupported cycle counts");
   end

   typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_ACTIVE, CY_RELEASE, CY_RECOVER} fcb_cycle_e;
   fcb_cycle_e state, next_state;
   logic [7:0] cnt, next_cnt;
   logic rd;
   logic [DW-1:0] dq_s1, dq_s2;
   fcb_strobe_s next_strobe;

   wire cnt_end = (cnt == 8'h01);
   wire take = start && state == CY_IDLE;
   wire is_rd = (state == CY_IDLE) ? is_read : rd;
   wire in_frame = next_state inside {CY_SETUP, CY_ACTIVE, CY_RELEASE};

   always_comb begin
      next_state = state;
      case (state)
         CY_IDLE: if (start) next_state = CY_SETUP;
         CY_SETUP: next_state = CY_ACTIVE;
         CY_ACTIVE: if (cnt_end) next_state = CY_RELEASE;
         CY_RELEASE: next_state = CY_RECOVER;
         CY_RECOVER: if (cnt_end) next_state = CY_IDLE;
         default: next_state = CY_IDLE;
      endcase
   end

   assign next_cnt = (state == CY_SETUP) ? 8'(ACT_CYC) :
                     (state == CY_RELEASE) ? 8'(REC_CYC) :
                     (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
   // ce stays low through release so the write strobe rises first
   assign next_strobe.ce_n = !in_frame;
   assign next_strobe.oe_n = !(next_state == CY_ACTIVE && is_rd);
   assign next_strobe.we_n = !(next_state == CY_ACTIVE && !is_rd);
   assign next_strobe.dq_oe_n = !(in_frame && !is_rd);

   always_ff @(posedge aclk) begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= CY_IDLE;
         cnt <= 8'h00;
         rd <= 1'b0;
         done <= 1'b0;
         strobe <= STROBE_IDLE;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         done <= (state == CY_RECOVER) && cnt_end;
         strobe <= next_strobe;
         if (take) rd <= is_read;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_addr <= '0;
         flash_dq_out <= '0;
         rdata <= '0;
      end else begin
         if (take) flash_addr <= addr_in;
         if (take) flash_dq_out <= wdata_in;
         if (rd && state == CY_ACTIVE && cnt_end) rdata <= dq_s2;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   strobe_excl_a: assert property (!(!strobe.oe_n && !strobe.we_n))
      else $error("output enable and write strobe low together");
   oe_release_a: assert property ($rose(strobe.oe_n) |-> strobe.oe_n [*2])
      else $error("output enable not returned high between reads");
   we_pulse_a: assert property ($fell(strobe.we_n) |-> !strobe.we_n [*4] ##1 strobe.we_n)
      else $error("write strobe width wrong");
   data_hold_a: assert property ($rose(strobe.we_n) |-> !strobe.ce_n && !strobe.dq_oe_n)
      else $error("data or chip select released before write strobe");
endmodule : fcb_bus_cycle

// ---- verification/fcb_flash_model.sv ----
// behavioural flash device seen by the command host
`timescale 1ns/10ps
module fcb_flash_model
   import fcb_pkg::*;
#(
   parameter logic [7:0] MAKER = 8'h3C, // arbitrary value
   parameter logic [7:0] PART = 8'h5B, // arbitrary value
   parameter logic [15:0] PAT = 16'hA5C3,
   parameter int LOCK_BLK = 5,
   parameter int BUSY_NS = 2000
)(
   input wire fcb_strobe_s strobe,
   input wire logic [20:0] addr,
   input wire logic [15:0] dq_in,
   output wire logic [15:0] dq_out,
   input wire logic reset_powerdown_n,
   input wire logic write_protect,
   input wire logic supply_ok,
   output wire ready_busy_n
);
   // uniform 32k-word blocks, block 0 the only boot block: a simplification
   bit [15:0] mem [0:2097151];
   logic [63:0] lock = 64'h1 << LOCK_BLK;
   logic perm = 1'b0;
   logic [7:0] sr = 8'h80;
   logic [7:0] snap = 8'h80;
   logic [7:0] pend = 8'h00;
   logic [1:0] mode = 2'd0; // 0 array, 1 identifier, 2 status
   logic armed = 1'b0;
   logic [15:0] last = 16'h0000;
   initial begin
      for (int i = 0; i < 2097152; i++) begin
         mem[i] = i[15:0] ^ PAT;
      end
   end
   function automatic logic [15:0] rd_val(input logic [20:0] a, input logic [1:0] m,
                                          input logic [7:0] sn);
      if (m == 2'd0) return mem[a];
      if (m == 2'd2) return {8'h00, sn};
      if (a == ID_MAKER_ADDR) return {8'h00, MAKER};
      if (a == ID_PART_ADDR) return {8'h00, PART};
      if (a == ID_PERM_LOCK_ADDR) return {15'h0000, perm};
      if (a[14:0] == ID_BLOCK_LOCK_OFS[14:0]) return {15'h0000, lock[a[20:15]]};
      return 16'h0000;
   endfunction : rd_val
   function automatic logic blocked(input logic [5:0] b);
      return lock[b] || (b == 6'd0 && !write_protect);
   endfunction : blocked
   wire drive = !strobe.ce_n && !strobe.oe_n && reset_powerdown_n;
   wire [15:0] dout = rd_val(addr, mode, snap);
   task automatic cmd(input logic [20:0] a, input logic [15:0] d);
      if (!sr[7] && d[7:0] != CMD_READ_STATUS) return; // busy ignores all commands but 70H
      if (pend == CMD_ERASE_SETUP) begin
         pend = 8'h00;
         mode = 2'd2;
         if (d[7:0] != CMD_CONFIRM) sr |= 8'h30;
         else if (!supply_ok) sr |= 8'h28;
         else if (blocked(a[20:15])) sr |= 8'h22;
         else begin
            for (int i = 0; i < 32768; i++) mem[{a[20:15], i[14:0]}] = 16'hFFFF;
            sr[7] = 1'b0;
            sr[7] <= #(BUSY_NS) 1'b1;
         end
      end else if (pend == CMD_WRITE_SETUP) begin
         pend = 8'h00;
         mode = 2'd2;
         if (!supply_ok) sr |= 8'h18;
         else if (blocked(a[20:15])) sr |= 8'h12;
         else begin
            mem[a] = d;
            sr[7] = 1'b0;
            sr[7] <= #(BUSY_NS / 4) 1'b1;
         end
      end else if (pend == 8'h60) begin
         pend = 8'h00;
         mode = 2'd2;
         if (d[7:0] == CMD_CONFIRM && !perm) lock = 64'h0;
         else if (d[7:0] == 8'h01 && !perm) lock[a[20:15]] = 1'b1;
         else if (d[7:0] == 8'hF1) perm = 1'b1; // set, never cleared
      end else begin
         case (d[7:0])
            CMD_READ_ARRAY: mode = 2'd0;
            CMD_READ_ID: mode = 2'd1;
            CMD_READ_STATUS: mode = 2'd2;
            CMD_CLEAR_STATUS: sr &= 8'hC5; // no suspend state here
            CMD_ERASE_SETUP, CMD_WRITE_SETUP, 8'h60: pend = d[7:0];
            8'h10: pend = CMD_WRITE_SETUP;
            default: ;
         endcase
      end
   endtask : cmd
   always @(negedge reset_powerdown_n) begin
      mode = 2'd0;
      pend = 8'h00;
   end
   always @(strobe.we_n or strobe.ce_n) begin // first rising strobe latches
      if (!strobe.we_n && !strobe.ce_n) armed = 1'b1;
      else if (armed) begin
         armed = 1'b0;
         cmd(addr, dq_in);
      end
   end
   always @(negedge strobe.oe_n or negedge strobe.ce_n) snap = sr;
   always @(drive or dout) if (drive) last = dout;
   // released lines show the inverse, so a stale sample cannot pass
   assign dq_out = drive ? dout : ~last;
   assign ready_busy_n = (!sr[7] && reset_powerdown_n) ? 1'b0 : 1'bz;
endmodule : fcb_flash_model

// ---- verification/test_flash_command_read_and_block_erase.sv ----
// self-checking bench: host registers, flash model, random traffic
`timescale 1ns/10ps
module test_flash_command_read_and_block_erase
   import fcb_pkg::*;
();
   localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
   localparam logic [7:0] PART = 8'h5B; // arbitrary value
   localparam logic [15:0] PAT = 16'hA5C3;
   localparam logic [5:0] LOCK_BLK = 6'h05;
   localparam int LIMIT = 20000;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, supply_ok, wpv;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   wire awready, wready, bvalid, arready, rvalid, rp_n, wp;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire fcb_strobe_s stb;
   wire [20:0] fa;
   wire [15:0] hdq, ddq;
   tri1 rb_n; // open-drain ready line with pull-up
   wire [15:0] dq = stb.dq_oe_n ? ddq : hdq;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int seed = 34;
   fcb_flash_host dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .flash_strobe(stb), .flash_addr(fa), .flash_dq_out(hdq), .flash_dq_in(dq),
      .reset_powerdown_n(rp_n), .write_protect(wp), .ready_busy_n(rb_n));
   fcb_flash_model #(.MAKER(MAKER), .PART(PART), .PAT(PAT), .LOCK_BLK(LOCK_BLK)) dev (
      .strobe(stb), .addr(fa), .dq_in(dq), .dq_out(ddq), .reset_powerdown_n(rp_n),
      .write_protect(wp), .supply_ok(supply_ok), .ready_busy_n(rb_n));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, s, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      // some writes keep the response waiting a cycle
      bready <= a[2];
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   // run one host operation to completion and return the flash data register
   task automatic op(input logic [2:0] c, input logic [20:0] a, input logic [15:0] d,
                     output logic [31:0] v);
      logic [31:0] s;
      logic [1:0] r;
      wr(REG_ADDR, {11'h000, a}, r);
      wr(REG_WDATA, {16'h0000, d}, r);
      wr(REG_CTRL, {22'h00_0000, wpv, 1'b1, 4'h0, 1'b1, c}, r);
      do rd(REG_STAT, s, r); while (s[STAT_BUSY_BIT] || !s[STAT_DONE_BIT]);
      rd(REG_RDATA, v, r);
   endtask : op
   task automatic t(input logic [2:0] c, input logic [20:0] a, input logic [15:0] d,
                    input logic [15:0] e, input string s);
      logic [31:0] v;
      op(c, a, d, v);
      chk(v, {16'h0000, e}, s);
   endtask : t
   function automatic logic [15:0] arr(input logic [20:0] a);
      return a[15:0] ^ PAT;
   endfunction : arr
   function automatic logic [15:0] stv(input logic [7:0] e);
      return {8'h00, 8'h80 | e};
   endfunction : stv
   function automatic logic [20:0] pick();
      logic [5:0] b;
      b = 6'(1 + {$random(seed)} % 62);
      if (b == LOCK_BLK) b = b + 6'h01;
      return {b, 15'($random(seed))};
   endfunction : pick
   initial begin
      logic [31:0] v;
      logic [1:0] r;
      logic [20:0] a;
      logic [20:0] b;
      logic [15:0] d;
      {aresetn, awvalid, wvalid, bready, arvalid, rready, wpv} = 7'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      supply_ok = 1'b1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(REG_CTRL, v, r);
      chk(v, 32'h0000_0100, "ctrl reset");
      rd(REG_STAT, v, r);
      chk(v & 32'h0000_0007, 32'h0000_0004, "stat reset");
      rd(8'h40, v, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
      wr(8'h44, 32'h0000_0000, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
      $display("test registers done");
      a = 21'($random(seed));
      t(OP_READ, a, 16'h0000, arr(a), "array after reset");
      t(OP_READ_ID, ID_MAKER_ADDR, 16'h0000, {8'h00, MAKER}, "maker");
      t(OP_READ_ID, ID_PART_ADDR, 16'h0000, {8'h00, PART}, "part");
      t(OP_READ_ID, ID_PERM_LOCK_ADDR, 16'h0000, 16'h0000, "perm lock");
      t(OP_READ_ID, {LOCK_BLK, 15'h0002}, 16'h0000, 16'h0001, "block lock");
      t(OP_READ, {6'h09, 15'h0002}, 16'h0000, 16'h0000, "id persists");
      t(OP_READ, ID_PART_ADDR, 16'h0000, {8'h00, PART}, "id persists");
      wr(REG_CTRL, 32'h0000_0000, r);
      chk({31'h0, rp_n}, 32'h0000_0000, "pin reset driven");
      wr(REG_CTRL, 32'h0000_0100, r);
      t(OP_READ, a, 16'h0000, arr(a), "array after pin reset");
      t(OP_READ_STATUS, a, 16'h0000, stv(8'h00), "status");
      t(OP_READ, a, 16'h0000, stv(8'h00), "status persists");
      $display("test read modes done");
      a = pick();
      t(OP_BLOCK_ERASE, a, 16'h0000, stv(8'h00), "erase ok");
      t(OP_READ, a, 16'h0000, stv(8'h00), "status after erase");
      op(OP_READ_ARRAY_MODE, a, 16'h0000, v);
      t(OP_READ, a ^ 21'h0_1234, 16'h0000, 16'hFFFF, "erased");
      b = a + 21'h0_8000;
      t(OP_READ, b, 16'h0000, arr(b), "neighbour kept");
      b = {LOCK_BLK, 15'($random(seed))};
      t(OP_BLOCK_ERASE, b, 16'h0000, stv(8'h22), "locked erase");
      t(OP_BLOCK_ERASE, pick(), 16'h0000, stv(8'h22), "flags sticky");
      op(3'h7, a, 16'h0000, v);
      t(OP_READ, b, 16'h0000, arr(b), "locked kept");
      op(OP_CLEAR_STATUS, a, 16'h0000, v);
      t(OP_READ_STATUS, a, 16'h0000, stv(8'h00), "flags cleared");
      $display("test erase done");
      b = {6'h00, 15'($random(seed))};
      t(OP_BLOCK_ERASE, b, 16'h0000, stv(8'h22), "boot protected");
      op(OP_CLEAR_STATUS, a, 16'h0000, v);
      wpv = 1'b1;
      t(OP_BLOCK_ERASE, b, 16'h0000, stv(8'h00), "boot erased");
      supply_ok <= 1'b0;
      t(OP_BLOCK_ERASE, pick(), 16'h0000, stv(8'h28), "low supply");
      op(OP_CLEAR_STATUS, a, 16'h0000, v);
      supply_ok <= 1'b1;
      $display("test protection done");
      for (int i = 0; i < 6; i++) begin
         a = pick();
         d = (i == 0) ? 16'h0000 : 16'($random(seed));
         t(OP_WORD_WRITE, a, d, stv(8'h00), "write ok");
         op(OP_READ_ARRAY_MODE, a, 16'h0000, v);
         t(OP_READ, a, 16'h0000, d, "word kept");
      end
      $display("test word writes done");
      report_and_stop();
   end
endmodule : test_flash_command_read_and_block_erase
